// ---- hdl/tsc_pkg.sv ----
package tsc_pkg;
  // pointer values that select a register
  localparam logic [7:0] PTR_TEMP  = 8'h00;
  localparam logic [7:0] PTR_CFG   = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;

  // power-on values
  localparam logic [7:0] PTR_RST   = 8'h00;
  localparam logic [7:0] CFG_RST   = 8'h40;
  localparam logic [7:0] UPPER_RST = 8'h7F;
  localparam logic [7:0] LOWER_RST = 8'h80;
  localparam logic [9:0] TEMP_RST  = 10'h000;

  // configuration bit positions
  localparam int CFG_SHUTDOWN  = 7;
  localparam int CFG_ALERT_DIS = 5;
  localparam int CFG_POL       = 4;
  localparam int CFG_ALERT_CLR = 3;
  localparam int CFG_ONESHOT   = 2;
  // action bits never stick in the stored value
  localparam logic [7:0] CFG_KEEP_MASK = 8'hF3;

  // second temperature byte flag positions
  localparam int FLG_ALERT = 5;
  localparam int FLG_ABOVE = 4;
  localparam int FLG_BELOW = 3;

  // smbus alert response address
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // timing, figures as printed, counts derived
  localparam int CLK_NS    = 10;
  localparam int WAKE_NS   = 4000;
  localparam int CONV_NS   = 25000;
  localparam int PERIOD_MS = 800;
  localparam int WAKE_CYC  = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC  = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERIOD_CYC_DEF = (PERIOD_MS * 1000000) / CLK_NS;

  // sensor front-end status carried together
  typedef struct packed {
    logic awake;
    logic converting;
    logic powered_down;
  } tsc_sensor_t;
endpackage

// ---- hdl/tsc_top.sv ----
// How it works
// - limit and config registers take one byte
// - write: address, pointer byte, one data byte
// - one byte per register, temperature two bytes
// - pointer kept between transactions
// - config D4 picks alert polarity, low default
// - config D5 set disables alert
// - alert asserts when temperature exceeds upper limit
// - D3 write or below lower clears alert
// - alert pin is open drain, pulls low
// - answer alert address only while pulling alert
// - arbitrate on own address, lowest wins
// - pointer selects temperature after reset
// - reset values 7Fh, 80h, 40h
// - automatic conversion every 800 ms
// - D2 starts one conversion, interval restarts
// - result dropped while serial access active
// - D7 set enters full power-down now, after a one-shot in flight
// - one-shot in power-down wakes 4 us, converts
// - stays down until D7 cleared or one-shot
// - serial access served while powered down
// - conversion takes 25 us after wake
// - pointers 0 temp, 2 upper, 3 lower
// - 10-bit temperature, high byte then low bits
// - limit flags clear on second byte read
`timescale 1ns/1ps
module tsc_top #(
  parameter int PERIOD_CYC = tsc_pkg::PERIOD_CYC_DEF
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [6:0]         dev_addr,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_n,
  input  wire logic               alert_in,
  output logic                    alert_out,
  output logic                    alert_oe_n,
  input  wire logic [9:0]         adc_result,
  output tsc_pkg::tsc_sensor_t    sensor_st
);
  import tsc_pkg::*;

  localparam int PW = $clog2(PERIOD_CYC + 1);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYC - 1);
  localparam logic [11:0]   WAKE_LAST   = 12'(WAKE_CYC - 1);
  localparam logic [11:0]   CONV_LAST   = 12'(CONV_CYC - 1);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_RACK, S_TX, S_TACK} tsc_bus_t;
  typedef enum logic [1:0] {C_SLEEP, C_WAKE, C_CONV} tsc_conv_t;

  //////////////////////////////////////////////////////////////////////////
  // declarations
  tsc_bus_t        bstate;        // serial slave state
  logic            scl_q;         // previous scl sample
  logic            sda_q;         // previous sda sample
  logic [3:0]      bit_cnt;       // bits of the current byte
  logic [7:0]      shreg;         // receive shifter
  logic [7:0]      txreg;         // transmit shifter
  logic [7:0]      ptr;           // address pointer
  logic [1:0]      byte_idx;      // byte number in transaction
  logic            rw;            // read transaction
  logic            ara;           // serving the alert address
  logic            acked;         // master acked last byte
  logic            wr_en;         // one-cycle register write
  logic [7:0]      wr_ptr;        // register written
  logic [7:0]      wr_data;       // data written
  logic            flag_clr;      // second temp byte read

  logic [7:0]      device_configuration; // mode, alert and power bits
  logic [7:0]      upper_temp_limit;     // alert set threshold
  logic [7:0]      lower_temp_limit;     // alert release threshold
  logic [9:0]      temp;          // stored temperature
  logic            alert_state;   // latched overtemperature
  logic            above_flag;    // above upper limit seen
  logic            below_lower_flag;

  tsc_conv_t       cstate;        // conversion sequencer
  logic [11:0]     ccnt;          // wake / conversion cycles
  logic            os_run;        // conversion was a one-shot
  logic [PW-1:0]   per_cnt;       // automatic interval counter

  logic scl_rise, scl_fall, start_c, stop_c;
  logic os_pulse, cfg_clr, full_powerdown_bit, period_tick;
  logic start_req, abort, conv_done, load;
  logic alert_act, pulling, ara_ok;
  logic hot, cold;
  logic [7:0] tx_first, tx_second;

  //////////////////////////////////////////////////////////////////////////
  // bus conditions, all inputs already synchronous
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

  // config write side effects
  assign os_pulse = wr_en && wr_ptr == PTR_CFG && wr_data[CFG_ONESHOT];
  assign cfg_clr  = wr_en && wr_ptr == PTR_CFG && wr_data[CFG_ALERT_CLR];
  assign full_powerdown_bit = device_configuration[CFG_SHUTDOWN];

  // alert is the latched state gated by the disable bit
  assign alert_act = alert_state & ~device_configuration[CFG_ALERT_DIS];
  // only an active-low alert is a pull on the shared line
  assign pulling   = alert_act & ~device_configuration[CFG_POL];
  assign ara_ok    = pulling & ~alert_in;

  // bytes offered to a read, chosen by pointer
  always_comb begin
    tx_second = 8'h00;
    if (ara) begin
      tx_first = {dev_addr, 1'b0};
    end else begin
      case (ptr)
        PTR_TEMP: begin
          tx_first  = temp[9:2];
          tx_second = {temp[1:0], alert_act, above_flag, below_lower_flag, 3'h0};
        end
        PTR_CFG:   tx_first = device_configuration;
        PTR_UPPER: tx_first = upper_temp_limit;
        PTR_LOWER: tx_first = lower_temp_limit;
        default:   tx_first = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line samples for edge and condition detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial slave: sample on scl rise, change sda on scl fall
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bstate   <= S_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      txreg    <= 8'h00;
      ptr      <= PTR_RST;
      byte_idx <= 2'h0;
      rw       <= 1'b0;
      ara      <= 1'b0;
      acked    <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_en    <= 1'b0;
      wr_ptr   <= 8'h00;
      wr_data  <= 8'h00;
      flag_clr <= 1'b0;
    end else begin
      wr_en    <= 1'b0;
      flag_clr <= 1'b0;
      if (start_c) begin
        // repeated start allowed; pointer survives it
        bstate   <= S_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        bstate   <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (bstate)
          S_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              if (shreg[7:1] == dev_addr) begin
                rw       <= shreg[0];
                ara      <= 1'b0;
                sda_oe_n <= 1'b0;
                bstate   <= S_AACK;
              end else if (shreg[7:1] == ARA_ADDR && shreg[0] && ara_ok) begin
                rw       <= 1'b1;
                ara      <= 1'b1;
                sda_oe_n <= 1'b0;
                bstate   <= S_AACK;
              end else begin
                bstate <= S_IDLE;  // not ours, wait for next start
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              bit_cnt  <= 4'h0;
              byte_idx <= 2'h0;
              if (rw) begin
                txreg    <= {tx_first[6:0], 1'b0};
                sda_oe_n <= tx_first[7];
                bstate   <= S_TX;
              end else begin
                sda_oe_n <= 1'b1;
                bstate   <= S_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              sda_oe_n <= 1'b0;
              bstate   <= S_RACK;
              if (byte_idx == 2'h0) begin
                ptr <= shreg;
              end else if (byte_idx == 2'h1) begin
                // only the first data byte lands; later ones are acked and dropped
                wr_en   <= 1'b1;
                wr_ptr  <= ptr;
                wr_data <= shreg;
              end
              if (byte_idx != 2'h2) begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= 4'h0;
              bstate   <= S_RX;
            end
          end
          S_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
              // released a one but line is low: lost arbitration
              if (ara && sda_oe_n && !sda_in) begin
                bstate <= S_IDLE;
              end
            end else if (scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                sda_oe_n <= 1'b1;
                bstate   <= S_TACK;
              end else begin
                sda_oe_n <= txreg[7];
                txreg    <= {txreg[6:0], 1'b0};
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              acked <= ~sda_in;
              if (!ara && ptr == PTR_TEMP && byte_idx == 2'h1) begin
                flag_clr <= 1'b1;
              end
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (acked) begin
                // past the last defined byte the device sends zeros
                byte_idx <= (byte_idx == 2'h2) ? byte_idx : byte_idx + 2'h1;
                if (byte_idx == 2'h0) begin
                  txreg    <= {tx_second[6:0], 1'b0};
                  sda_oe_n <= tx_second[7];
                end else begin
                  txreg    <= 8'h00;
                  sda_oe_n <= 1'b0;
                end
                bstate <= S_TX;
              end else begin
                bstate <= S_IDLE;  // nack ends the read, stop follows
              end
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register file, reachable in every power mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      device_configuration <= CFG_RST;
      upper_temp_limit     <= UPPER_RST;
      lower_temp_limit     <= LOWER_RST;
    end else if (wr_en) begin
      case (wr_ptr)
        PTR_CFG:   device_configuration <= wr_data & CFG_KEEP_MASK;
        PTR_UPPER: upper_temp_limit     <= wr_data;
        PTR_LOWER: lower_temp_limit     <= wr_data;
        default:   device_configuration <= device_configuration;  // temperature is read only
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // automatic interval; starts full so the first conversion follows reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt <= PERIOD_LAST;
    end else if (os_pulse || full_powerdown_bit || per_cnt == PERIOD_LAST) begin
      per_cnt <= '0;
    end else begin
      per_cnt <= per_cnt + PW'(1);
    end
  end
  assign period_tick = per_cnt == PERIOD_LAST && !full_powerdown_bit;

  //////////////////////////////////////////////////////////////////////////
  // conversion sequencer: wake, convert, sleep
  assign start_req = os_pulse | period_tick;
  // power-down cuts a periodic conversion short, not a one-shot
  assign abort     = full_powerdown_bit & ~os_run & cstate != C_SLEEP;
  assign conv_done = cstate == C_CONV && ccnt == CONV_LAST && !abort;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cstate <= C_SLEEP;
      ccnt   <= 12'h000;
      os_run <= 1'b0;
    end else if (start_req) begin
      // a one-shot restarts any conversion in flight
      cstate <= C_WAKE;
      ccnt   <= 12'h000;
      os_run <= os_pulse;
    end else if (abort) begin
      cstate <= C_SLEEP;
      ccnt   <= 12'h000;
    end else begin
      case (cstate)
        C_WAKE: begin
          if (ccnt == WAKE_LAST) begin
            cstate <= C_CONV;
            ccnt   <= 12'h000;
          end else begin
            ccnt <= ccnt + 12'h001;
          end
        end
        C_CONV: begin
          if (ccnt == CONV_LAST) begin
            cstate <= C_SLEEP;
            ccnt   <= 12'h000;
            os_run <= 1'b0;
          end else begin
            ccnt <= ccnt + 12'h001;
          end
        end
        default: begin
          ccnt <= 12'h000;  // asleep, partial or full
        end
      endcase
    end
  end

  // front-end power and activity, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sensor_st <= '0;
    end else begin
      sensor_st.awake        <= cstate != C_SLEEP;
      sensor_st.converting   <= cstate == C_CONV;
      sensor_st.powered_down <= full_powerdown_bit & cstate == C_SLEEP;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result load, refused while the slave is busy so no torn read
  assign load = conv_done && bstate == S_IDLE;
  assign hot  = $signed(adc_result) > $signed({upper_temp_limit, 2'h0});
  assign cold = $signed(adc_result) < $signed({lower_temp_limit, 2'h0});

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp <= TEMP_RST;
    end else if (load) begin
      temp <= adc_result;
    end
  end

  // latched alert; a new overtemperature beats any clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_state <= 1'b0;
    end else if (load && hot) begin
      alert_state <= 1'b1;
    end else if (cfg_clr || (load && cold)) begin
      alert_state <= 1'b0;
    end
  end

  // limit flags, set wins over the read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      above_flag       <= 1'b0;
      below_lower_flag <= 1'b0;
    end else begin
      if (load && hot) begin
        above_flag <= 1'b1;
      end else if (flag_clr) begin
        above_flag <= 1'b0;
      end
      if (load && cold) begin
        below_lower_flag <= 1'b1;
      end else if (flag_clr) begin
        below_lower_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // open-drain pins: output data is always low, only the enable moves
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out    <= 1'b0;
      alert_out  <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      sda_out   <= 1'b0;
      alert_out <= 1'b0;
      // active high means the line is held low while inactive
      alert_oe_n <= ~(alert_act ^ device_configuration[CFG_POL]);
    end
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tsc_pkg::*;
  localparam logic [6:0] ADDR = 7'h4A; // strap, arbitrary
  localparam int         PER  = 20000; // shortened interval
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  adc = 10'h1A5;
  logic        scl;
  logic        mst_sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic        alert_out;
  logic        alert_oe_n;
  tsc_sensor_t st;
  logic [15:0] v;
  logic [7:0]  q8;
  logic        a;
  int          err_total = 0;
  int          n_checks = 0;
  logic [7:0]  pc [5] = '{8'h50, 8'h60, 8'h40, 8'h48, 8'h40}; // cfg sequence
  logic        pe [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};      // pin released?
  wire         sda = mst_sda & (sda_oe_n | sda_out); // pulled-up wire
  wire         alert = alert_oe_n | alert_out;       // pulled-up wire
  always #5 mclk = ~mclk;
  tsc_top #(.PERIOD_CYC(PER)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .dev_addr(ADDR), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_in(alert), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .adc_result(adc), .sensor_st(st));
  tsc_master i_mst (.mclk(mclk), .sda_in(sda), .scl(scl), .sda(mst_sda));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait so a one-shot never restarts a conversion
  task automatic idle_wait();
    for (int k = 0; k < 4000 && (st.awake | st.converting) === 1'b1; k++) begin
      @(posedge mclk);
    end
    #1;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input bit wd);
    logic [7:0] q;
    logic       k;
    i_mst.start();
    i_mst.xfer({ADDR, 1'b0}, 1'b1, q, k);
    chk("wr_ack", {7'h00, k}, 8'h00);
    i_mst.xfer(p, 1'b1, q, k);
    if (wd) begin
      i_mst.xfer(d, 1'b1, q, k);
    end
    i_mst.stop();
  endtask
  // master acks all but the last byte
  task automatic rd(input logic [6:0] ad, input int n, output logic [15:0] r, output logic k);
    logic [7:0] q;
    logic       m;
    r = 16'h0000;
    i_mst.start();
    i_mst.xfer({ad, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      i_mst.xfer(8'hFF, (i == n - 1), q, m);
      r = {r[7:0], q};
    end
    i_mst.stop();
  endtask
  task automatic rdr(input logic [7:0] p, input int n);
    wr(p, 8'h00, 1'b0);
    rd(ADDR, n, v, a);
  endtask
  task automatic shot();
    idle_wait();
    wr(PTR_CFG, 8'h44, 1'b1);
  endtask
  ////////////////////////////////////////
  // twice the expected run length
  initial begin
    #1000000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    cyc(3200);
    rd(ADDR, 2, v, a);
    chk("boot_hi", v[15:8], 8'h69);
    chk("boot_lo", v[7:0], 8'h40);
    rdr(PTR_CFG, 1);
    chk("cfg_rst", v[7:0], 8'h40);
    rdr(PTR_UPPER, 1);
    chk("upper_rst", v[7:0], 8'h7F);
    rdr(PTR_LOWER, 1);
    chk("lower_rst", v[7:0], 8'h80);
    rd(ADDR, 1, v, a);
    chk("reread", v[7:0], 8'h80);
    rd(ADDR ^ 7'h01, 1, v, a);
    chk("other_ack", {7'h00, a}, 8'h01);
    wr(PTR_UPPER, 8'h50, 1'b1);
    rdr(PTR_UPPER, 1);
    chk("upper_wr", v[7:0], 8'h50);
    // a second data byte is acked but must not land
    i_mst.start();
    i_mst.xfer({ADDR, 1'b0}, 1'b1, q8, a);
    i_mst.xfer(PTR_UPPER, 1'b1, q8, a);
    i_mst.xfer(8'h50, 1'b1, q8, a);
    i_mst.xfer(8'h33, 1'b1, q8, a);
    i_mst.stop();
    rd(ADDR, 1, v, a);
    chk("upper_one", v[7:0], 8'h50);
    shot();
    rdr(PTR_CFG, 1);
    chk("cfg_self", v[7:0], 8'h40);
    cyc(3200);
    chk("alert_on", {7'h00, alert_oe_n}, 8'h00);
    rdr(PTR_TEMP, 2);
    chk("flags_set", v[7:0], 8'h70);
    rd(ADDR, 2, v, a);
    chk("flags_clr", v[7:0], 8'h60);
    rd(ARA_ADDR, 1, v, a);
    chk("ara_ack", {7'h00, a}, 8'h00);
    chk("ara_byte", v[7:0], {ADDR, 1'b0});
    for (int i = 0; i < 5; i++) begin
      wr(PTR_CFG, pc[i], 1'b1);
      chk("alert_pin", {7'h00, alert_oe_n}, {7'h00, pe[i]});
    end
    rd(ARA_ADDR, 1, v, a);
    chk("ara_idle", {7'h00, a}, 8'h01);
    shot();
    cyc(3200);
    chk("alert_again", {7'h00, alert_oe_n}, 8'h00);
    adc = 10'h3F0;
    wr(PTR_LOWER, 8'h00, 1'b1);
    shot();
    cyc(3200);
    chk("alert_low", {7'h00, alert_oe_n}, 8'h01);
    // hold a transaction open across the load
    adc = 10'h100;
    shot();
    i_mst.start();
    i_mst.xfer({ADDR, 1'b0}, 1'b1, q8, a);
    cyc(3200);
    i_mst.stop();
    rdr(PTR_TEMP, 2);
    chk("discard", v[15:8], 8'hFC);
    shot();
    cyc(3200);
    rd(ADDR, 2, v, a);
    chk("load", v[15:8], 8'h40);
    idle_wait();
    wr(PTR_CFG, 8'h80, 1'b1);
    adc = 10'h080;
    chk("down_on", {7'h00, st.powered_down}, 8'h01);
    cyc(PER + 100);
    rdr(PTR_TEMP, 2);
    chk("down_hold", v[15:8], 8'h40);
    wr(PTR_CFG, 8'h84, 1'b1);
    cyc(3200);
    chk("down_back", {5'h00, st}, 8'h01);
    rdr(PTR_TEMP, 2);
    chk("down_shot", v[15:8], 8'h20);
    wr(PTR_CFG, 8'h00, 1'b1);
    chk("down_off", {7'h00, st.powered_down}, 8'h00);
    conclude();
  end
endmodule

// ---- sim/tsc_master.sv ----
`timescale 1ns/1ps
module tsc_master (
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda
);
  // clock high, data released between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // four mclk a level, above the slave's three
  task automatic hold();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // one pulse, sampled late in the high half
  task automatic bitx(input logic b, output logic s);
    sda = b;
    hold();
    scl = 1'b1;
    hold();
    s = sda_in;
    scl = 1'b0;
  endtask
  // data falls while clock high
  task automatic start();
    sda = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda = 1'b0;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda = 1'b1;
    hold();
  endtask
  // eight bits msb first, then the ninth slot
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic ka);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ak, ka);
  endtask
endmodule

// ---- sim/tsc_monitor.sv ----
`timescale 1ns/1ps
module tsc_monitor #(
  parameter int PERIOD_CYC = tsc_pkg::PERIOD_CYC_DEF
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic [6:0]           dev_addr,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe_n,
  input wire logic                 alert_in,
  input wire logic                 alert_out,
  input wire logic                 alert_oe_n,
  input wire logic [9:0]           adc_result,
  input wire tsc_pkg::tsc_sensor_t sensor_st
);
  import tsc_pkg::*;
  // slack of two, phase edges are registered
  localparam int WAKE_LO = WAKE_CYC - 2;
  localparam int WAKE_HI = WAKE_CYC + 2;
  localparam int CONV_LO = CONV_CYC - 2;
  localparam int CONV_HI = CONV_CYC + 2;
  int wake_cnt; // cycles up, not converting
  int conv_cnt; // cycles converting
  int gap_cnt;  // cycles since last wake-up
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // phase lengths, counted rather than unrolled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= 0;
      conv_cnt <= 0;
    end else begin
      wake_cnt <= (sensor_st.awake && !sensor_st.converting) ? wake_cnt + 1 : 0;
      conv_cnt <= sensor_st.converting ? conv_cnt + 1 : 0;
    end
  end
  // interval held while powered down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 0;
    end else begin
      gap_cnt <= (sensor_st.powered_down || $rose(sensor_st.awake)) ? 0 : gap_cnt + 1;
    end
  end
  ////////////////////////////////////////
  chk_sda_pull_only: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  chk_alert_drain: assert property (alert_out == 1'b0)
    else $error("alert driven high");
  chk_sda_high_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda moved while clock high");
  chk_boot_conv: assert property ($rose(rst_n) |-> ##[1:3] sensor_st.awake)
    else $error("no conversion after reset");
  chk_wake_time: assert property ($rose(sensor_st.converting) |-> wake_cnt inside {[WAKE_LO:WAKE_HI]})
    else $error("wake-up length wrong");
  chk_conv_time: assert property ($fell(sensor_st.converting) |-> conv_cnt inside {[CONV_LO:CONV_HI]})
    else $error("conversion length wrong");
  chk_period_max: assert property (gap_cnt <= PERIOD_CYC + 8)
    else $error("periodic conversion missing");
  chk_down_quiet: assert property (sensor_st.powered_down && !sensor_st.awake |-> !sensor_st.converting)
    else $error("converting while down");
endmodule
bind tsc_top tsc_monitor #(.PERIOD_CYC(PERIOD_CYC)) i_mon (
  .mclk(mclk), .rst_n(rst_n), .dev_addr(dev_addr), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_in(alert_in),
  .alert_out(alert_out), .alert_oe_n(alert_oe_n), .adc_result(adc_result), .sensor_st(sensor_st));
